// ---- src/memory_map_config.sv ----
module memory_map_config
    import memory_map_config_pkg::*;
#(
    parameter int          AW           = 16,
    parameter int          E_DIV        = 4,
    parameter logic        REMAP        = 1'b0,
    parameter logic        SECURITY_OPT = 1'b1,
    parameter int          RAM_BYTES    = 512,
    parameter logic [15:0] EE_BASE      = 16'hB600,
    parameter int          EE_BYTES     = 512,
    parameter logic [15:0] ROM_BASE     = 16'hD000
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    // AXI4-Lite register bus
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // pins
    input  wire logic          modeAPin,
    input  wire logic          modeBPin,
    input  wire logic [7:0]    nvConfigByte,
    input  wire logic          testResetDisable,
    // cpu address to decode
    input  wire logic [15:0]   cpuAddr,
    // decode and control outputs
    output region_e            region,
    output logic               watchdogEnable,
    output logic               securityOn,
    output logic               irqEdgeOnly,
    output logic               oscStartupDelayEn,
    output logic [1:0]         watchdogRateSel,
    output logic               specialModeFlag,
    output logic               initDone,
    // nonvolatile byte programming
    output logic               nvProgStb,
    output logic [7:0]         nvProgData
);
    `include "memory_map_config_regs.svh"

    localparam int IW = AW - 2;

    if (E_DIV < 2 || E_DIV > 255 || AW < 16 || AW > 32) begin : g_chk
        $error("memory_map_config: unsupported E_DIV or AW");
    end

    reg_access_if #(.IW(IW)) ra ();

    axil_reg_slave #(.AW(AW)) u_slave (
        .clk     (ref_clk),
        .rst     (sys_rst),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .ra      (ra)
    );

    // pin synchronisers
    logic [10:0] pinMeta_ff, pinSync_ff;
    logic [7:0]  nvSync;
    logic        modeASync, modeBSync, testDisSync;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinMeta_ff <= 11'h000;
            pinSync_ff <= 11'h000;
        end else begin
            pinMeta_ff <= {testResetDisable, modeBPin, modeAPin, nvConfigByte};
            pinSync_ff <= pinMeta_ff;
        end
    end

    assign nvSync      = pinSync_ff[7:0];
    assign modeASync   = pinSync_ff[8];
    assign modeBSync   = pinSync_ff[9];
    assign testDisSync = pinSync_ff[10];

    // reset sequence: wait for synchronisers, load latches, run
    init_state_e state_ff, nxt_state;
    logic [1:0]  holdCnt_ff, nxt_holdCnt;
    mode_e       mode_ff, nxt_mode;

    always_comb begin
        nxt_state   = state_ff;
        nxt_holdCnt = holdCnt_ff;
        nxt_mode    = mode_ff;
        case (state_ff)
            ST_HOLD: begin
                nxt_holdCnt = holdCnt_ff + 2'd1;
                if (holdCnt_ff == `LOAD_SYNC_CYCLES - 2'd1)
                    nxt_state = ST_LOAD;
            end
            ST_LOAD: begin
                nxt_state = ST_RUN;
                nxt_mode  = mode_e'({modeBSync, modeASync});
            end
            ST_RUN:  nxt_state = ST_RUN;
            default: nxt_state = ST_HOLD;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff   <= ST_HOLD;
            holdCnt_ff <= 2'd0;
            mode_ff    <= MODE_SINGLE;
        end else begin
            state_ff   <= nxt_state;
            holdCnt_ff <= nxt_holdCnt;
            mode_ff    <= nxt_mode;
        end
    end

    logic  isSpecial, running;
    mode_e loadMode;

    assign loadMode  = mode_e'({modeBSync, modeASync});
    assign isSpecial = !mode_ff[1];
    assign running   = (state_ff == ST_RUN);

    // watchdog latch copy kept across reset, hence no reset on this flop
    logic cfgWd_ff, wdHold_ff;

    always_ff @(posedge ref_clk) begin
        if (running)
            wdHold_ff <= cfgWd_ff;
    end

    // configuration working latches
    logic [3:0] cfgPage_ff, nxt_cfgPage;
    logic       cfgSec_ff, cfgRom_ff, cfgEe_ff;
    logic       nxt_cfgSec, nxt_cfgWd, nxt_cfgRom, nxt_cfgEe;
    logic       loadSpecial, loadExpTest, loadSingleBoot;

    always_comb begin
        loadSpecial    = !loadMode[1];
        loadExpTest    = loadMode[0];
        loadSingleBoot = !loadMode[0];
        nxt_cfgPage    = cfgPage_ff;
        nxt_cfgSec     = cfgSec_ff;
        nxt_cfgWd      = cfgWd_ff;
        nxt_cfgRom     = cfgRom_ff;
        nxt_cfgEe      = cfgEe_ff;
        if (state_ff == ST_LOAD) begin
            nxt_cfgSec = !SECURITY_OPT || loadExpTest || nvSync[3];
            nxt_cfgWd  = loadSpecial ? wdHold_ff : nvSync[2];
            if (REMAP) begin
                nxt_cfgPage = loadSingleBoot ? `EE_PAGE_TOP : nvSync[7:4];
                nxt_cfgRom  = 1'b1;
                if (loadSingleBoot)
                    nxt_cfgEe = 1'b1;
                else if (loadMode == MODE_TEST)
                    nxt_cfgEe = 1'b0;
                else
                    nxt_cfgEe = nvSync[0];
            end else begin
                nxt_cfgPage = 4'h0;
                nxt_cfgRom  = (loadMode == MODE_SINGLE) || nvSync[1];
                nxt_cfgEe   = nvSync[0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgPage_ff <= `EE_PAGE_TOP;
            cfgSec_ff  <= 1'b1;
            cfgWd_ff   <= 1'b1;
            cfgRom_ff  <= 1'b1;
            cfgEe_ff   <= 1'b0;
        end else begin
            cfgPage_ff <= nxt_cfgPage;
            cfgSec_ff  <= nxt_cfgSec;
            cfgWd_ff   <= nxt_cfgWd;
            cfgRom_ff  <= nxt_cfgRom;
            cfgEe_ff   <= nxt_cfgEe;
        end
    end

    // E clock enable and 64-cycle write window
    logic [7:0] eDiv_ff, nxt_eDiv;
    logic [6:0] winCnt_ff, nxt_winCnt;
    logic       eTick, winOpen;

    assign eTick   = (eDiv_ff == 8'(E_DIV - 1));
    assign winOpen = running && (winCnt_ff < `WINDOW_E_CYCLES);

    always_comb begin
        nxt_eDiv   = eTick ? 8'h00 : eDiv_ff + 8'h01;
        nxt_winCnt = winCnt_ff;
        if (running && eTick && winOpen)
            nxt_winCnt = winCnt_ff + 7'd1;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            eDiv_ff   <= 8'h00;
            winCnt_ff <= 7'd0;
        end else begin
            eDiv_ff   <= nxt_eDiv;
            winCnt_ff <= nxt_winCnt;
        end
    end

    // placement, options and programming writes
    logic [7:0] place_ff, nxt_place, opt_ff, nxt_opt, nxt_progData;
    logic       placeDone_ff, nxt_placeDone, optDone_ff, nxt_optDone, nxt_progStb;
    logic       wrOk;

    always_comb begin
        wrOk          = ra.wrStb && ra.wrLane0 && running;
        nxt_place     = place_ff;
        nxt_placeDone = placeDone_ff;
        nxt_opt       = opt_ff;
        nxt_optDone   = optDone_ff;
        nxt_progStb   = 1'b0;
        nxt_progData  = nvProgData;
        if (wrOk && ra.wrIdx == IW'(`IDX_PLACEMENT)) begin
            if (isSpecial) begin
                nxt_place = ra.wrData;
            end else if (winOpen && !placeDone_ff) begin
                nxt_place     = ra.wrData;
                nxt_placeDone = 1'b1;
            end
        end
        if (wrOk && ra.wrIdx == IW'(`IDX_OPTIONS)) begin
            if (isSpecial) begin
                nxt_opt = ra.wrData & `OPT_IMPL_MASK;
            end else begin
                nxt_opt = (opt_ff & ~`OPT_ANYTIME_MASK) | (ra.wrData & `OPT_ANYTIME_MASK);
                if (winOpen && !optDone_ff) begin
                    nxt_opt = (nxt_opt & ~`OPT_ONCE_MASK)
                            | (ra.wrData & `OPT_ONCE_MASK);
                    nxt_optDone = 1'b1;
                end
            end
        end
        if (wrOk && ra.wrIdx == IW'(`IDX_NV_PROGRAM)) begin
            nxt_progStb  = 1'b1;
            nxt_progData = ra.wrData;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            place_ff     <= `PLACEMENT_RESET;
            placeDone_ff <= 1'b0;
            opt_ff       <= `OPTIONS_RESET;
            optDone_ff   <= 1'b0;
            nvProgStb    <= 1'b0;
            nvProgData   <= 8'h00;
        end else begin
            place_ff     <= nxt_place;
            placeDone_ff <= nxt_placeDone;
            opt_ff       <= nxt_opt;
            optDone_ff   <= nxt_optDone;
            nvProgStb    <= nxt_progStb;
            nvProgData   <= nxt_progData;
        end
    end

    // register reads and address hits; late writes still answer OKAY
    logic [7:0] cfgRead;

    always_comb begin
        if (REMAP)
            cfgRead = {cfgPage_ff, cfgSec_ff, cfgWd_ff, 1'b1, cfgEe_ff};
        else
            cfgRead = {4'h0, cfgSec_ff, cfgWd_ff, cfgRom_ff, cfgEe_ff};
        ra.rdHit  = 1'b1;
        ra.rdData = 8'h00;
        case (ra.rdIdx)
            IW'(`IDX_CONFIG):     ra.rdData = cfgRead;
            IW'(`IDX_PLACEMENT):  ra.rdData = place_ff;
            IW'(`IDX_OPTIONS):    ra.rdData = opt_ff;
            IW'(`IDX_NV_PROGRAM): ra.rdData = nvSync;
            default:              ra.rdHit  = 1'b0;
        endcase
        case (ra.wrIdx)
            IW'(`IDX_CONFIG), IW'(`IDX_PLACEMENT),
            IW'(`IDX_OPTIONS), IW'(`IDX_NV_PROGRAM): ra.wrHit = 1'b1;
            default:                                 ra.wrHit = 1'b0;
        endcase
    end

    // registered control outputs
    logic nxt_wdEn;

    always_comb begin
        if (isSpecial)
            nxt_wdEn = !testDisSync;
        else
            nxt_wdEn = !cfgWd_ff;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            watchdogEnable  <= 1'b0;
            securityOn      <= 1'b0;
            specialModeFlag <= 1'b0;
            initDone        <= 1'b0;
        end else begin
            watchdogEnable  <= running && nxt_wdEn;
            securityOn      <= running && !cfgSec_ff;
            specialModeFlag <= running && isSpecial;
            initDone        <= running;
        end
    end

    assign irqEdgeOnly       = opt_ff[`OPT_IRQ_EDGE];
    assign oscStartupDelayEn = opt_ff[`OPT_OSC_DELAY];
    assign watchdogRateSel   = opt_ff[1:0];

    map_decoder #(
        .REMAP     (REMAP),
        .RAM_BYTES (RAM_BYTES),
        .EE_BASE   (EE_BASE),
        .EE_BYTES  (EE_BYTES),
        .ROM_BASE  (ROM_BASE)
    ) u_decoder (
        .clk     (ref_clk),
        .rst     (sys_rst),
        .addr    (cpuAddr),
        .regPage (place_ff[3:0]),
        .ramPage (place_ff[7:4]),
        .eePage  (cfgPage_ff),
        .eeprom_present    (cfgEe_ff),
        .rom_present   (cfgRom_ff || (mode_ff == MODE_SINGLE)),
        .region  (region)
    );
endmodule // memory_map_config

// ---- src/memory_map_config_regs.svh ----
`ifndef MEMORY_MAP_CONFIG_REGS_SVH
`define MEMORY_MAP_CONFIG_REGS_SVH

// register indices; byte address is four times the index
`define IDX_OPTIONS      14'h1039
`define IDX_PLACEMENT    14'h103D
`define IDX_CONFIG       14'h103F
`define IDX_NV_PROGRAM   14'h1041

// reset values
`define PLACEMENT_RESET  8'h01
`define OPTIONS_RESET    8'h00
`define EE_PAGE_TOP      4'hF

// options register field positions and masks
`define OPT_IRQ_EDGE     5
`define OPT_OSC_DELAY    4
`define OPT_IMPL_MASK    8'hFB
`define OPT_ANYTIME_MASK 8'hC8
`define OPT_ONCE_MASK    8'h33

// timing counts
`define WINDOW_E_CYCLES  7'd64
`define LOAD_SYNC_CYCLES 2'd3

// AXI responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ---- src/memory_map_config_pkg.sv ----
package memory_map_config_pkg;
    // encoding is {mode B pin, mode A pin}
    typedef enum logic [1:0] {
        MODE_BOOT   = 2'b00,
        MODE_TEST   = 2'b01,
        MODE_SINGLE = 2'b10,
        MODE_EXP    = 2'b11
    } mode_e;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b11
    } init_state_e;

    typedef enum logic [2:0] {
        REG_EXTERNAL = 3'h0,
        REG_CTRL     = 3'h1,
        REG_RAM      = 3'h2,
        REG_EEPROM   = 3'h3,
        REG_ROM      = 3'h4
    } region_e;
endpackage

// ---- src/reg_access_if.sv ----
interface reg_access_if #(parameter int IW = 14);
    logic          wrStb;
    logic [IW-1:0] wrIdx;
    logic [7:0]    wrData;
    logic          wrLane0;
    logic          wrHit;
    logic [IW-1:0] rdIdx;
    logic [7:0]    rdData;
    logic          rdHit;

    modport bus  (output wrStb, wrIdx, wrData, wrLane0, rdIdx,
                  input  wrHit, rdData, rdHit);
    modport regs (input  wrStb, wrIdx, wrData, wrLane0, rdIdx,
                  output wrHit, rdData, rdHit);
endinterface

// ---- src/axil_reg_slave.sv ----
module axil_reg_slave #(
    parameter int AW = 16
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    reg_access_if.bus          ra
);
    `include "memory_map_config_regs.svh"

    logic          awHeld_ff, wHeld_ff, nxt_awHeld, nxt_wHeld;
    logic [AW-3:0] awIdx_ff, nxt_awIdx;
    logic [7:0]    wByte_ff, nxt_wByte;
    logic          wLane_ff, nxt_wLane;
    logic          nxt_bvalid, nxt_rvalid;
    logic [1:0]    nxt_bresp, nxt_rresp;
    logic [31:0]   nxt_rdata;

    assign ra.wrStb   = awHeld_ff && wHeld_ff && !bvalid;
    assign ra.wrIdx   = awIdx_ff;
    assign ra.wrData  = wByte_ff;
    assign ra.wrLane0 = wLane_ff;
    assign ra.rdIdx   = araddr[AW-1:2];

    always_comb begin
        nxt_awHeld = awHeld_ff;
        nxt_wHeld  = wHeld_ff;
        nxt_awIdx  = awIdx_ff;
        nxt_wByte  = wByte_ff;
        nxt_wLane  = wLane_ff;
        nxt_bvalid = bvalid && !bready;
        nxt_bresp  = bresp;
        nxt_rvalid = rvalid && !rready;
        nxt_rresp  = rresp;
        nxt_rdata  = rdata;
        if (awvalid && awready) begin
            nxt_awHeld = 1'b1;
            nxt_awIdx  = awaddr[AW-1:2];
        end
        if (wvalid && wready) begin
            nxt_wHeld = 1'b1;
            nxt_wByte = wdata[7:0];
            nxt_wLane = wstrb[0];
        end
        if (ra.wrStb) begin
            nxt_awHeld = 1'b0;
            nxt_wHeld  = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = ra.wrHit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (arvalid && arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = ra.rdHit ? `RESP_OKAY : `RESP_SLVERR;
            nxt_rdata  = {24'h000000, ra.rdData};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            awIdx_ff  <= '0;
            wByte_ff  <= 8'h00;
            wLane_ff  <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
            rvalid    <= 1'b0;
            rresp     <= `RESP_OKAY;
            rdata     <= 32'h00000000;
            awready   <= 1'b1;
            wready    <= 1'b1;
            arready   <= 1'b1;
        end else begin
            awHeld_ff <= nxt_awHeld;
            wHeld_ff  <= nxt_wHeld;
            awIdx_ff  <= nxt_awIdx;
            wByte_ff  <= nxt_wByte;
            wLane_ff  <= nxt_wLane;
            bvalid    <= nxt_bvalid;
            bresp     <= nxt_bresp;
            rvalid    <= nxt_rvalid;
            rresp     <= nxt_rresp;
            rdata     <= nxt_rdata;
            awready   <= !nxt_awHeld && !nxt_bvalid;
            wready    <= !nxt_wHeld && !nxt_bvalid;
            arready   <= !nxt_rvalid;
        end
    end
endmodule // axil_reg_slave

// ---- src/map_decoder.sv ----
module map_decoder
    import memory_map_config_pkg::*;
#(
    parameter logic        REMAP     = 1'b0,
    parameter int          RAM_BYTES = 512,
    parameter logic [15:0] EE_BASE   = 16'hB600,
    parameter int          EE_BYTES  = 512,
    parameter logic [15:0] ROM_BASE  = 16'hD000
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] addr,
    input  wire logic [3:0]  regPage,
    input  wire logic [3:0]  ramPage,
    input  wire logic [3:0]  eePage,
    input  wire logic        eeprom_present,
    input  wire logic        rom_present,
    output region_e          region
);
    logic    hitCtrl, hitRam, hitEe, hitRom;
    region_e nxt_region;

    always_comb begin
        hitCtrl = (addr[15:12] == regPage) && (addr[11:6] == 6'h00);
        hitRam  = (addr[15:12] == ramPage) && ({4'h0, addr[11:0]} < 16'(RAM_BYTES));
        if (REMAP)
            hitEe = eeprom_present && (addr[15:12] == eePage) && addr[11];
        else
            hitEe = eeprom_present && (addr >= EE_BASE) && ((addr - EE_BASE) < 16'(EE_BYTES));
        hitRom  = rom_present && (addr >= ROM_BASE);
        if (hitCtrl)
            nxt_region = REG_CTRL;
        else if (hitRam)
            nxt_region = REG_RAM;
        else if (hitEe)
            nxt_region = REG_EEPROM;
        else if (hitRom)
            nxt_region = REG_ROM;
        else
            nxt_region = REG_EXTERNAL;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            region <= REG_EXTERNAL;
        else
            region <= nxt_region;
    end
endmodule // map_decoder

// ---- tb/memory_map_config_chk.sv ----
module memory_map_config_chk (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // status
    input wire logic        initDone,
    input wire logic        securityOn,
    input wire logic        specialModeFlag,
    input wire logic        testResetDisable,
    input wire logic        watchdogEnable,
    input wire logic        nvProgStb
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // cycles since reset release, saturating
    logic [2:0] relCnt_ff;
    logic [2:0] nxt_relCnt;
    always_comb nxt_relCnt = (relCnt_ff == 3'h7) ? relCnt_ff : relCnt_ff + 3'h1;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) relCnt_ff <= 3'h0;
        else relCnt_ff <= nxt_relCnt;
    end
    sequence s_testOff;
        // pin to output takes two sync stages plus the output register
        (specialModeFlag && testResetDisable) [*4];
    endsequence
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_sec_init: assert property (!initDone |-> !securityOn)
        else $error("security active before load");
    a_init_time: assert property (initDone == (relCnt_ff >= 3'h5))
        else $error("latch load at wrong cycle");
    a_wd_test: assert property (s_testOff |-> !watchdogEnable)
        else $error("watchdog runs despite test disable");
    a_prog_pulse: assert property (nvProgStb |=> !nvProgStb)
        else $error("program strobe too long");
endmodule // memory_map_config_chk
bind memory_map_config memory_map_config_chk chk (.ref_clk, .sys_rst, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .initDone, .securityOn,
    .specialModeFlag, .testResetDisable, .watchdogEnable, .nvProgStb);

// ---- tb/testbench.sv ----
`include "memory_map_config_regs.svh"
module testbench
    import memory_map_config_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] OPT = {`IDX_OPTIONS, 2'b00};
    localparam logic [15:0] PLC = {`IDX_PLACEMENT, 2'b00};
    localparam logic [15:0] CFG = {`IDX_CONFIG, 2'b00};
    localparam logic [15:0] PRG = {`IDX_NV_PROGRAM, 2'b00};
    logic        ref_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, modeAPin, modeBPin, testResetDisable, watchdogEnable;
    logic        securityOn, irqEdgeOnly, oscStartupDelayEn, specialModeFlag, initDone;
    logic        nvProgStb;
    logic [15:0] s_axi_awaddr, s_axi_araddr, cpuAddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, watchdogRateSel, rs;
    logic [7:0]  nvConfigByte, nvProgData;
    region_e     region;
    int          n_errors, check_count;
    memory_map_config dut (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .modeAPin, .modeBPin, .nvConfigByte,
        .testResetDisable, .cpuAddr, .region, .watchdogEnable, .securityOn, .irqEdgeOnly,
        .oscStartupDelayEn, .watchdogRateSel, .specialModeFlag, .initDone, .nvProgStb,
        .nvProgData);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task print_verdict;
        $display("checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask
    task tmo;
        chk(32'h0, 32'h1);
        print_verdict();
    endtask
    // master holds each channel until its own ready, bready until bvalid
    task wr(input logic [15:0] a, input logic [7:0] d);
        int i;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (i == 64) tmo();
    endtask
    task rd(input logic [15:0] a);
        int i;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 64) tmo();
    endtask
    task rc(input logic [15:0] a, input logic [7:0] e);
        rd(a);
        chk(rv, {24'h000000, e});
    endtask
    task rg(input logic [15:0] a, input region_e e);
        @(posedge ref_clk);
        cpuAddr <= a;
        repeat (3) @(posedge ref_clk);
        chk(32'(region), 32'(e));
    endtask
    task boot(input logic b, input logic a, input logic [7:0] n);
        int i;
        sys_rst <= 1'b1;
        modeBPin <= b;
        modeAPin <= a;
        nvConfigByte <= n;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 20 && initDone !== 1'b1; i++) @(posedge ref_clk);
        if (i == 20) tmo();
    endtask
    task t_single;
        boot(1'b1, 1'b0, 8'hF0);
        rc(CFG, 8'h02);
        chk(securityOn, 1'b1);
        chk(watchdogEnable, 1'b1);
        wr(CFG, 8'hFF);
        rc(CFG, 8'h02);
        wr(PRG, 8'h5A);
        chk(nvProgData, 8'h5A);
        rc(PRG, 8'hF0);
        rc(PLC, 8'h01);
        rg(16'h1000, REG_CTRL);
        rg(16'h0000, REG_RAM);
        rg(16'hD000, REG_ROM);
        rg(16'hB600, REG_EXTERNAL);
        wr(PLC, 8'h23);
        wr(PLC, 8'h45);
        chk(rs, `RESP_OKAY);
        rc(PLC, 8'h23);
        rg(16'h3000, REG_CTRL);
        rg(16'h2000, REG_RAM);
        wr(OPT, 8'hFF);
        rc(OPT, 8'hFB);
        chk({irqEdgeOnly, oscStartupDelayEn, watchdogRateSel}, 4'hF);
        wr(OPT, 8'h00);
        rc(OPT, 8'h33);
        rd(16'h4000);
        chk(rs, `RESP_SLVERR);
    endtask
    task t_exp;
        boot(1'b1, 1'b1, 8'h05);
        rc(CFG, 8'h0D);
        chk(securityOn, 1'b0);
        chk(watchdogEnable, 1'b0);
        rg(16'hD000, REG_EXTERNAL);
        rg(16'hB600, REG_EEPROM);
        nvConfigByte <= 8'h00;
        repeat (300) @(posedge ref_clk);
        rc(CFG, 8'h0D);
        wr(PLC, 8'h55);
        rc(PLC, 8'h01);
        wr(OPT, 8'hF8);
        rc(OPT, 8'hC8);
    endtask
    task t_test;
        boot(1'b0, 1'b1, 8'h00);
        rc(CFG, 8'h0C);
        chk(specialModeFlag, 1'b1);
        testResetDisable <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(watchdogEnable, 1'b0);
        testResetDisable <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(watchdogEnable, 1'b1);
        repeat (300) @(posedge ref_clk);
        wr(PLC, 8'h77);
        wr(PLC, 8'h11);
        rc(PLC, 8'h11);
        rg(16'h1000, REG_CTRL);
        rg(16'h1100, REG_RAM);
        wr(OPT, 8'hFF);
        rc(OPT, 8'hFB);
    endtask
    initial begin
        {sys_rst, modeBPin, s_axi_wstrb} = 6'h3F;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {modeAPin, testResetDisable, s_axi_awaddr, s_axi_araddr, cpuAddr} = 50'h0;
        s_axi_wdata = 32'h00000000;
        nvConfigByte = 8'hF0;
        n_errors = 0;
        check_count = 0;
        t_single();
        t_exp();
        t_test();
        print_verdict();
    end
endmodule // testbench
